// file: rtl/pll_d_bank_pkg.sv
// constants and register map of the fourth pll configuration bank
package pll_d_bank_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_AMOUNT_A    = 8'h40;
  localparam logic [7:0] IDX_AMOUNT_B    = 8'h41;
  localparam logic [7:0] IDX_AMOUNT_C    = 8'h42;
  localparam logic [7:0] IDX_VCO_SELECT  = 8'h43;
  localparam logic [7:0] IDX_MUX_STATES  = 8'h44;
  localparam logic [7:0] IDX_STATE_CHOICE = 8'h45;
  localparam logic [7:0] IDX_SPREAD_TYPE = 8'h46;
  localparam int         REG_COUNT       = 7;

  // reset values and the spread type write mask
  localparam logic [7:0] RST_AMOUNT       = 8'h00;
  localparam logic [7:0] RST_VCO_SELECT   = 8'h00;
  localparam logic [7:0] RST_MUX_STATES   = 8'hED;
  localparam logic [7:0] RST_STATE_CHOICE = 8'h02;
  localparam logic [7:0] RST_SPREAD_TYPE  = 8'h00;
  localparam logic [7:0] MASK_SPREAD_TYPE = 8'h80;

  // fields of the mux and output state register, the spread type bit and the amount field width
  localparam int BIT_BYPASS    = 7;
  localparam int BIT_OUT8_SRC  = 6;
  localparam int LSB_OUT9_SRC  = 4;
  localparam int LSB_DEF_ONE   = 2;
  localparam int LSB_DEF_ZERO  = 0;
  localparam int BIT_SPREAD_TYPE = 7;
  localparam int AMOUNT_BITS   = 3;

  // output state definition codes
  localparam logic [1:0] OST_HIZ_PD  = 2'h0;
  localparam logic [1:0] OST_HIZ_ON  = 2'h1;
  localparam logic [1:0] OST_LOW_ON  = 2'h2;
  localparam logic [1:0] OST_ACTIVE  = 2'h3;

  // out9 source codes
  localparam logic [1:0] OUT9_DIV_SIX   = 2'h0;
  localparam logic [1:0] OUT9_DIV_EIGHT = 2'h1;
  localparam logic [1:0] OUT9_DIV_NINE  = 2'h2;

  // deviation in quarter percent steps for off and for the top amount code, and the top code itself
  localparam logic [3:0] DEV_OFF  = 4'h0;
  localparam logic [3:0] DEV_2P0  = 4'h8;
  localparam logic [2:0] CODE_MAX = 3'h7;

endpackage

// file: rtl/pll_d_bank.sv
// apb register bank steering the fourth pll per control state
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pll_d_bank
  import pll_d_bank_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              state_select_pin_a,
  input  wire logic              state_select_pin_b,
  input  wire logic              state_select_pin_c,
  output logic      [2:0]        pll_d_spread_amount,
  output logic      [3:0]        pll_d_spread_quarter_pct,
  output logic                   pll_d_spread_type,
  output logic                   pll_d_vco_set_select,
  output logic                   pll_d_bypass_select,
  output logic                   pll_d_powerdown,
  output logic                   out8_source_select,
  output logic      [1:0]        out9_source_select,
  output logic      [1:0]        out89_state
);

  // every check below runs on the one system clock, off during reset
  default clocking chk_clk @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
    return 8'(a >> 2);
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = word_index(a);
    return (a[1:0] == 2'h0) && (i >= IDX_AMOUNT_A) &&
           (i <= IDX_SPREAD_TYPE) && ((a >> 10) == '0);
  endfunction

  // code 111 gives two percent (eight quarter steps); every other code keeps its own value
  function automatic logic [3:0] deviation(input logic [2:0] code);
    if (code == CODE_MAX)
      return DEV_2P0;
    else
      return {1'b0, code};
  endfunction

  // ----------------------------------------------------------------
  // state pin synchroniser
  // ----------------------------------------------------------------
  logic [2:0] sel_meta_q;
  logic [2:0] sel_q;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sel_meta_q <= 3'h0;
      sel_q      <= 3'h0;
    end
    else
    begin
      sel_meta_q <= {state_select_pin_c, state_select_pin_b,
                     state_select_pin_a};
      sel_q      <= sel_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // apb slave and register file
  // ----------------------------------------------------------------
  logic [7:0]  regs_q [REG_COUNT];
  logic [7:0]  regs_d [REG_COUNT];
  logic        ready_q, ready_d;
  logic        err_q, err_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0]  idx;
  logic        commit;

  // answer one cycle into the access phase; registered outputs
  always_comb
  begin
    idx     = word_index(paddr) - IDX_AMOUNT_A;
    commit  = psel && penable && ready_q;
    ready_d = psel && penable && !ready_q;
    err_d   = ready_d && !is_mapped(paddr);
    rdata_d = rdata_q;
    if (ready_d)
      rdata_d = (is_mapped(paddr) && !pwrite) ? {24'h0, regs_q[idx[2:0]]}
                                              : 32'h0;
    for (int k = 0; k < REG_COUNT; k++)
      regs_d[k] = regs_q[k];
    if (commit && pwrite && !err_q)
    begin
      if (word_index(paddr) == IDX_SPREAD_TYPE)
        regs_d[idx[2:0]] = pwdata[7:0] & MASK_SPREAD_TYPE;
      else
        regs_d[idx[2:0]] = pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      regs_q[0] <= RST_AMOUNT;
      regs_q[1] <= RST_AMOUNT;
      regs_q[2] <= RST_AMOUNT;
      regs_q[3] <= RST_VCO_SELECT;
      regs_q[4] <= RST_MUX_STATES;
      regs_q[5] <= RST_STATE_CHOICE;
      regs_q[6] <= RST_SPREAD_TYPE;
      ready_q   <= 1'b0;
      err_q     <= 1'b0;
      rdata_q   <= 32'h0;
    end
    else
    begin
      for (int k = 0; k < REG_COUNT; k++)
        regs_q[k] <= regs_d[k];
      ready_q <= ready_d;
      err_q   <= err_d;
      rdata_q <= rdata_d;
    end
  end

  assign pready  = ready_q;
  assign pslverr = err_q;
  assign prdata  = rdata_q;

  // ----------------------------------------------------------------
  // per-state application
  // ----------------------------------------------------------------
  logic [23:0] amounts;
  logic [7:0]  mux_reg;
  logic [2:0]  amt_q, amt_d;
  logic [3:0]  dev_q, dev_d;
  logic        type_q, type_d, vco_q, vco_d, byp_q, byp_d;
  logic        pd_q, pd_d, o8_q, o8_d;
  logic [1:0]  o9_q, o9_d, ost_q, ost_d;

  always_comb
  begin
    amounts = {regs_q[0], regs_q[1], regs_q[2]};
    mux_reg = regs_q[4];
    amt_d   = amounts[sel_q*AMOUNT_BITS +: AMOUNT_BITS];
    type_d  = regs_q[6][BIT_SPREAD_TYPE];
    dev_d   = deviation(amt_d);
    vco_d   = regs_q[3][sel_q];
    byp_d   = mux_reg[BIT_BYPASS];
    o8_d    = mux_reg[BIT_OUT8_SRC];
    o9_d    = mux_reg[LSB_OUT9_SRC +: 2];
    if (regs_q[5][sel_q])
      ost_d = mux_reg[LSB_DEF_ONE +: 2];
    else
      ost_d = mux_reg[LSB_DEF_ZERO +: 2];
    pd_d    = byp_d || (ost_d == OST_HIZ_PD);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      amt_q  <= 3'h0;
      dev_q  <= DEV_OFF;
      type_q <= 1'b0;
      vco_q  <= 1'b0;
      byp_q  <= 1'b1;
      pd_q   <= 1'b1;
      o8_q   <= 1'b1;
      o9_q   <= OUT9_DIV_NINE;
      ost_q  <= OST_HIZ_ON;
    end
    else
    begin
      amt_q  <= amt_d;
      dev_q  <= dev_d;
      type_q <= type_d;
      vco_q  <= vco_d;
      byp_q  <= byp_d;
      pd_q   <= pd_d;
      o8_q   <= o8_d;
      o9_q   <= o9_d;
      ost_q  <= ost_d;
    end
  end

  assign pll_d_spread_amount      = amt_q;
  assign pll_d_spread_quarter_pct = dev_q;
  assign pll_d_spread_type        = type_q;
  assign pll_d_vco_set_select     = vco_q;
  assign pll_d_bypass_select      = byp_q;
  assign pll_d_powerdown          = pd_q;
  assign out8_source_select       = o8_q;
  assign out9_source_select       = o9_q;
  assign out89_state              = ost_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  amount_follows_state_a: assert property (
    1'b1 |=> amt_q == $past(amounts[sel_q*AMOUNT_BITS +: AMOUNT_BITS]))
    else $error("spread amount not the selected state field");
  top_code_two_pct_a: assert property (
    amt_q == CODE_MAX |-> dev_q == DEV_2P0)
    else $error("code 111 not two percent");
  low_codes_linear_a: assert property (
    amt_q != CODE_MAX |-> dev_q == {1'b0, amt_q})
    else $error("deviation step mismatch");
  vco_follows_state_a: assert property (
    1'b1 |=> vco_q == $past(regs_q[3][sel_q]))
    else $error("vco set select mismatch");
  bypass_powers_down_a: assert property (
    byp_q |-> pd_q)
    else $error("bypass without power down");
  out_source_bits_a: assert property (
    1'b1 |=> o8_q == $past(mux_reg[BIT_OUT8_SRC]) &&
             o9_q == $past(mux_reg[LSB_OUT9_SRC +: 2]))
    else $error("output source mismatch");
  state_def_choice_a: assert property (
    1'b1 |=> ost_q == ($past(regs_q[5][sel_q])
                       ? $past(mux_reg[LSB_DEF_ONE +: 2])
                       : $past(mux_reg[LSB_DEF_ZERO +: 2])))
    else $error("output state definition mismatch");
  hiz_pd_powers_down_a: assert property (
    ost_q == OST_HIZ_PD |-> pd_q)
    else $error("definition 00 without power down");
  pin_to_state_a: assert property (
    1'b1 |-> ##2 sel_q == $past({state_select_pin_c, state_select_pin_b,
                                 state_select_pin_a}, 2))
    else $error("state pins not synchronised in two cycles");
  apb_one_wait_a: assert property (
    psel && penable && !ready_q |=> ready_q)
    else $error("apb answer not one cycle into access");

endmodule // pll_d_bank
`default_nettype wire

// file: testbench/state_ctrl_model.sv
// far-side controller model driving the three state select pins
`timescale 1ns/1ps
`default_nettype none
module state_ctrl_model
(
  input  wire logic       sys_clk,
  input  wire logic [2:0] state_req,
  output logic            pin_a,
  output logic            pin_b,
  output logic            pin_c
);
  // pins move only just after an edge, like a synchronous controller
  always_ff @(posedge sys_clk)
  begin
    {pin_c, pin_b, pin_a} <= state_req;
  end
endmodule // state_ctrl_model
`default_nettype wire

// file: testbench/pll_d_bank_test.sv
// self-checking bench for the fourth pll configuration bank
`timescale 1ns/1ps
`default_nettype none
module pll_d_bank_test import pll_d_bank_pkg::*;;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        sys_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0;
  logic [2:0]  state_req = 3'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_a;
  logic        pin_b;
  logic        pin_c;
  wire  [16:0] outs;
  logic [7:0]  m [7];
  logic [7:0]  rnd       = 8'h51;
  int          n_fail    = 0;
  int          n_compared = 0;

  always #10 sys_clk = ~sys_clk;

  pll_d_bank #(.ADDR_W(12)) uut
  (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .state_select_pin_a(pin_a),
    .state_select_pin_b(pin_b), .state_select_pin_c(pin_c),
    .pll_d_spread_amount(outs[16:14]), .pll_d_spread_quarter_pct(outs[13:10]),
    .pll_d_spread_type(outs[9]), .pll_d_vco_set_select(outs[8]),
    .pll_d_bypass_select(outs[7]), .pll_d_powerdown(outs[6]),
    .out8_source_select(outs[5]), .out9_source_select(outs[4:3]),
    .out89_state(outs[2:1])
  );
  assign outs[0] = 1'b0;

  state_ctrl_model partner
  (
    .sys_clk(sys_clk), .state_req(state_req),
    .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk_bus(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch bus at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [16:0] got, input logic [16:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch out at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  // answer taken at the rising edge where pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [32:0] ans);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge sys_clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      n_fail++;
      give_verdict();
    end
    ans = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [16:0] exp_out(input int s);
    logic [23:0] sp;
    logic [2:0]  c;
    logic [1:0]  d;
    sp = {m[0], m[1], m[2]};
    c = sp[3*s +: 3];
    d = m[5][s] ? m[4][3:2] : m[4][1:0];
    return {c, (c == 3'h7) ? 4'h8 : {1'b0, c}, m[6][7],
            m[3][s], m[4][7], m[4][7] | (d == 2'h0),
            m[4][6], m[4][5:4], d, 1'b0};
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [32:0] ans;
    logic [7:0]  v;
    int          k;
    int          r;
    int          s;
    m = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hED, 8'h02, 8'h00};
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (r = 0; r < 4; r++)
    begin
      apb(1'b1, 12'h101, 8'h5A, ans);
      chk_bus({ans[32], 32'h0}, {1'b1, 32'h0});
      apb(1'b0, 12'h11C, 8'h00, ans);
      chk_bus(ans, {1'b1, 32'h0});
      for (k = 0; k < 7; k++)
      begin
        apb(1'b0, 12'(12'h100 + 4 * k), 8'h00, ans);
        chk_bus(ans, {1'b0, 24'h0, m[k]});
      end
      // sweep every state without touching the registers
      for (s = 0; s < 8; s++)
      begin
        @(posedge sys_clk);
        state_req <= 3'(s);
        repeat (5) @(negedge sys_clk);
        chk_out(outs, exp_out(s));
      end
      if (r == 3)
        break;
      for (k = 0; k < 7; k++)
      begin
        rnd = lfsr_next(rnd);
        v = (r == 2) ? 8'hFF : rnd;
        apb(1'b1, 12'(12'h100 + 4 * k), v, ans);
        chk_bus({ans[32], 32'h0}, 33'h0);
        m[k] = (k == 6) ? (v & 8'h80) : v;
      end
    end
    give_verdict();
  end
endmodule // pll_d_bank_test
`default_nettype wire
